// ==== rtl/cdt_pkg.sv ====
// constants shared by the cascadable dual timer
package cdt_pkg;
	// register indices as printed (byte address = 4 * index)
	localparam logic [9:0] IDX_LOW_COUNT   = 10'h106;
	localparam logic [9:0] IDX_HIGH_HOLD   = 10'h108;
	localparam logic [9:0] IDX_HIGH_COUNT  = 10'h10a;
	localparam logic [9:0] IDX_LOW_PERIOD  = 10'h10c;
	localparam logic [9:0] IDX_HIGH_PERIOD = 10'h10e;
	localparam logic [9:0] IDX_LOW_CTRL    = 10'h110;
	localparam logic [9:0] IDX_HIGH_CTRL   = 10'h112;
	localparam logic [9:0] IDX_IRQ_FLAG    = 10'h114;
	localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h116;
	localparam logic [9:0] IDX_SYS_CTRL    = 10'h118;
	localparam int         ADDR_LSB        = 2;
	// control register fields
	localparam int BIT_TIMER_ON    = 15;
	localparam int BIT_IDLE_STOP   = 13;
	localparam int BIT_GATE_EN     = 6;
	localparam int BIT_PS_HI       = 5;
	localparam int BIT_PS_LO       = 4;
	localparam int BIT_WIDE_MODE   = 3;
	localparam int BIT_CLK_SRC     = 1;
	localparam logic [15:0] CTRL_MASK_LOW  = 16'ha07a;
	localparam logic [15:0] CTRL_MASK_HIGH = 16'ha072;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] PERIOD_RESET   = 16'hffff;
	localparam logic [15:0] ZERO16         = 16'h0000;
	// interrupt flag/enable bits: period flag of each half
	localparam int BIT_IRQ_LOW  = 6;
	localparam int BIT_IRQ_HIGH = 7;
	// system control bits
	localparam int BIT_SLEEP = 0;
	localparam int BIT_IDLE  = 1;
	// prescale terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PS_TC1   = 8'h00;
	localparam logic [7:0] PS_TC8   = 8'h07;
	localparam logic [7:0] PS_TC64  = 8'h3f;
	localparam logic [7:0] PS_TC256 = 8'hff;
endpackage : cdt_pkg

// ==== rtl/cdt_prescaler.sv ====
// prescaler: divides qualified input ticks by 1, 8, 64 or 256
`timescale 1ns/1ps
module cdt_prescaler (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       tick_in,
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	// result
	output logic            tick_out
);
	logic [7:0] cnt_r;
	logic [7:0] tc;
	always_comb begin
		case (sel)
			2'b00:   tc = cdt_pkg::PS_TC1;
			2'b01:   tc = cdt_pkg::PS_TC8;
			2'b10:   tc = cdt_pkg::PS_TC64;
			default: tc = cdt_pkg::PS_TC256;
		endcase
	end
	assign tick_out = tick_in && (cnt_r >= tc);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= 8'h00;
		else if (clear)
			cnt_r <= 8'h00;
		else if (tick_in)
			cnt_r <= tick_out ? 8'h00 : cnt_r + 8'h01;
	end
endmodule : cdt_prescaler

// ==== rtl/cdt_sync.sv ====
// three-stage synchroniser for the external gate/clock pin
`timescale 1ns/1ps
module cdt_sync (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin and result
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic [2:0] s_r;
	logic       level_r;
	// a change counts only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r     <= 3'b000;
			level_r <= 1'b0;
		end else begin
			s_r <= {s_r[1:0], pin};
			if (s_r[1] == s_r[2])
				level_r <= s_r[2];
		end
	end
	assign level = level_r;
	assign rise  = (s_r[1] == s_r[2]) && s_r[2] && !level_r;
	assign fall  = (s_r[1] == s_r[2]) && !s_r[2] && level_r;
endmodule : cdt_sync

// ==== rtl/cdt_timer.sv ====
// cascadable dual 16-bit / single 32-bit timer with apb register access
`timescale 1ns/1ps
module cdt_timer (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic        gate_input_pin,
	input  wire logic        high_clk_pin,
	// events
	output logic             adc_trigger,
	output logic             irq
);
	logic [15:0] low_count_r, high_count_r, hold_r;
	logic [15:0] low_period_r, high_period_r;
	logic [15:0] low_ctrl_r, high_ctrl_r;
	logic [1:0]  flag_r, enable_r;
	logic [1:0]  sys_r;
	logic [31:0] prdata_r;
	logic        adc_r, irq_r;

	// bus decode; access completes in its first access cycle
	wire         wr_en  = psel && penable && pwrite;
	wire         rd_en  = psel && penable && !pwrite;
	localparam int ADDR_LSB_W = cdt_pkg::ADDR_LSB;
	wire [9:0]   idx    = paddr[11:ADDR_LSB_W];
	wire         aligned = (paddr[1:0] == 2'b00);
	wire         hit_lc  = aligned && idx == cdt_pkg::IDX_LOW_COUNT;
	wire         hit_hh  = aligned && idx == cdt_pkg::IDX_HIGH_HOLD;
	wire         hit_hc  = aligned && idx == cdt_pkg::IDX_HIGH_COUNT;
	wire         hit_lp  = aligned && idx == cdt_pkg::IDX_LOW_PERIOD;
	wire         hit_hp  = aligned && idx == cdt_pkg::IDX_HIGH_PERIOD;
	wire         hit_lx  = aligned && idx == cdt_pkg::IDX_LOW_CTRL;
	wire         hit_hx  = aligned && idx == cdt_pkg::IDX_HIGH_CTRL;
	wire         hit_fl  = aligned && idx == cdt_pkg::IDX_IRQ_FLAG;
	wire         hit_en  = aligned && idx == cdt_pkg::IDX_IRQ_ENABLE;
	wire         hit_sy  = aligned && idx == cdt_pkg::IDX_SYS_CTRL;
	wire         mapped  = hit_lc | hit_hh | hit_hc | hit_lp | hit_hp | hit_lx | hit_hx | hit_fl | hit_en | hit_sy;
	wire         w_lc = wr_en && hit_lc;
	wire         w_hc = wr_en && hit_hc;
	wire         w_lx = wr_en && hit_lx;
	wire         w_hx = wr_en && hit_hx;
	wire         w_fl = wr_en && hit_fl;

	// control fields
	wire         wide      = low_ctrl_r[cdt_pkg::BIT_WIDE_MODE];
	wire         sleep     = sys_r[cdt_pkg::BIT_SLEEP];
	wire         idle      = sys_r[cdt_pkg::BIT_IDLE];
	wire         lo_on     = low_ctrl_r[cdt_pkg::BIT_TIMER_ON];
	wire         lo_ext    = low_ctrl_r[cdt_pkg::BIT_CLK_SRC];
	wire         lo_gate   = low_ctrl_r[cdt_pkg::BIT_GATE_EN] && !lo_ext;
	wire         lo_idls   = low_ctrl_r[cdt_pkg::BIT_IDLE_STOP];
	wire         hi_on     = high_ctrl_r[cdt_pkg::BIT_TIMER_ON];
	wire         hi_ext    = high_ctrl_r[cdt_pkg::BIT_CLK_SRC];
	wire         hi_idls   = high_ctrl_r[cdt_pkg::BIT_IDLE_STOP];
	wire [1:0]   lo_ps     = low_ctrl_r[cdt_pkg::BIT_PS_HI:cdt_pkg::BIT_PS_LO];
	wire [1:0]   hi_ps     = high_ctrl_r[cdt_pkg::BIT_PS_HI:cdt_pkg::BIT_PS_LO];

	// external pins through synchronisers
	wire         gate_lvl, gate_rise, gate_fall;
	wire         hclk_rise;
	cdt_sync u_gate_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (gate_input_pin),
		.level   (gate_lvl),
		.rise    (gate_rise),
		.fall    (gate_fall)
	);
	cdt_sync u_hclk_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (high_clk_pin),
		.level   (),
		.rise    (hclk_rise),
		.fall    ()
	);
	wire         gate_end = lo_on && lo_gate && gate_fall;

	// raw ticks: sleep stops all clocks, idle stops when idle_stop set
	wire         lo_run  = lo_on && !sleep && !(idle && lo_idls);
	wire         hi_run  = hi_on && !sleep && !(idle && hi_idls);
	wire         lo_src  = lo_ext ? gate_rise : (lo_gate ? gate_lvl : 1'b1);
	wire         hi_src  = hi_ext ? hclk_rise : 1'b1;
	wire         lo_tick_raw = lo_run && lo_src;
	wire         hi_tick_raw = !wide && hi_run && hi_src;

	// low prescaler is not cleared while the timer is off (clock halted)
	wire         lo_ps_clr = (w_lc || w_hc || w_lx || w_hx) && lo_on;
	wire         hi_ps_clr = w_lc || w_hc || w_lx || w_hx;
	wire         lo_tick, hi_tick;
	cdt_prescaler u_lo_ps (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (lo_tick_raw),
		.clear    (lo_ps_clr),
		.sel      (lo_ps),
		.tick_out (lo_tick)
	);
	cdt_prescaler u_hi_ps (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (hi_tick_raw),
		.clear    (hi_ps_clr),
		.sel      (hi_ps),
		.tick_out (hi_tick)
	);

	// match detection
	wire [31:0]  cnt32   = {high_count_r, low_count_r};
	wire [31:0]  per32   = {high_period_r, low_period_r};
	wire         m32     = wide && lo_tick && (cnt32 == per32);
	wire         m_lo    = !wide && lo_tick && (low_count_r == low_period_r);
	wire         m_hi    = !wide && hi_tick && (high_count_r == high_period_r);
	wire [31:0]  cnt32_inc = cnt32 + 32'h0000_0001;

	// count next values; software writes take priority over counting
	logic [15:0] low_count_nxt, high_count_nxt;
	always_comb begin
		low_count_nxt  = low_count_r;
		high_count_nxt = high_count_r;
		if (wide) begin
			if (m32) begin
				low_count_nxt  = cdt_pkg::ZERO16;
				high_count_nxt = cdt_pkg::ZERO16;
			end else if (lo_tick) begin
				low_count_nxt  = cnt32_inc[15:0];
				high_count_nxt = cnt32_inc[31:16];
			end
		end else begin
			if (m_lo)
				low_count_nxt = cdt_pkg::ZERO16;
			else if (lo_tick)
				low_count_nxt = low_count_r + 16'h0001;
			if (m_hi)
				high_count_nxt = cdt_pkg::ZERO16;
			else if (hi_tick)
				high_count_nxt = high_count_r + 16'h0001;
		end
		if (w_lc) begin
			low_count_nxt = pwdata[15:0];
			if (wide)
				high_count_nxt = hold_r;
		end
		if (w_hc)
			high_count_nxt = pwdata[15:0];
	end

	// hardware sets win over software clears; software writes 1 to clear
	wire [1:0]   flag_set = {m32 || m_hi || (wide && gate_end), m_lo || (!wide && gate_end)};

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_count_r   <= cdt_pkg::ZERO16;
			high_count_r  <= cdt_pkg::ZERO16;
			hold_r        <= cdt_pkg::ZERO16;
			low_period_r  <= cdt_pkg::PERIOD_RESET;
			high_period_r <= cdt_pkg::PERIOD_RESET;
			low_ctrl_r    <= cdt_pkg::CTRL_RESET;
			high_ctrl_r   <= cdt_pkg::CTRL_RESET;
			enable_r      <= 2'b00;
			sys_r         <= 2'b00;
		end else begin
			low_count_r  <= low_count_nxt;
			high_count_r <= high_count_nxt;
			if (rd_en && hit_lc)
				hold_r <= high_count_r;
			else if (wr_en && hit_hh)
				hold_r <= pwdata[15:0];
			if (wr_en && hit_lp)
				low_period_r <= pwdata[15:0];
			if (wr_en && hit_hp)
				high_period_r <= pwdata[15:0];
			if (w_lx)
				low_ctrl_r <= pwdata[15:0] & cdt_pkg::CTRL_MASK_LOW;
			if (w_hx)
				high_ctrl_r <= pwdata[15:0] & cdt_pkg::CTRL_MASK_HIGH;
			if (wr_en && hit_en)
				enable_r <= {pwdata[cdt_pkg::BIT_IRQ_HIGH], pwdata[cdt_pkg::BIT_IRQ_LOW]};
			if (wr_en && hit_sy)
				sys_r <= pwdata[1:0];
		end
	end

	// flag bits map to bits 6 and 7 of the flag word
	logic [15:0] flag_word, enable_word;
	always_comb begin
		flag_word   = cdt_pkg::ZERO16;
		enable_word = cdt_pkg::ZERO16;
		flag_word[cdt_pkg::BIT_IRQ_LOW]    = flag_r[0];
		flag_word[cdt_pkg::BIT_IRQ_HIGH]   = flag_r[1];
		enable_word[cdt_pkg::BIT_IRQ_LOW]  = enable_r[0];
		enable_word[cdt_pkg::BIT_IRQ_HIGH] = enable_r[1];
	end

	// read mux
	logic [15:0] rd_word;
	always_comb begin
		rd_word = cdt_pkg::ZERO16;
		if (hit_lc) rd_word = low_count_r;
		if (hit_hh) rd_word = hold_r;
		if (hit_hc) rd_word = high_count_r;
		if (hit_lp) rd_word = low_period_r;
		if (hit_hp) rd_word = high_period_r;
		if (hit_lx) rd_word = low_ctrl_r;
		if (hit_hx) rd_word = high_ctrl_r;
		if (hit_fl) rd_word = flag_word;
		if (hit_en) rd_word = enable_word;
		if (hit_sy) rd_word = {14'h0000, sys_r};
	end

	// flag write uses bit positions 6/7 of the written word
	wire [1:0] flag_clr_bits = {pwdata[cdt_pkg::BIT_IRQ_HIGH], pwdata[cdt_pkg::BIT_IRQ_LOW]};
	wire [1:0] flag_next_v   = (flag_r & ~(w_fl ? flag_clr_bits : 2'b00)) | flag_set;

	// outputs and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r   <= 2'b00;
			prdata_r <= 32'h0000_0000;
			adc_r    <= 1'b0;
			irq_r    <= 1'b0;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			flag_r   <= flag_next_v;
			prdata_r <= (psel && !penable && !pwrite) ? {16'h0000, rd_word} : prdata_r;
			adc_r    <= m32 || m_hi;
			irq_r    <= |(flag_next_v & enable_r);
			pready   <= psel && !penable;
			pslverr  <= psel && !penable && !mapped;
		end
	end
	assign prdata      = prdata_r;
	assign adc_trigger = adc_r;
	assign irq         = irq_r;

	chk_adc_on_match: assert property (@(posedge pclk) disable iff (!presetn)
		(m32 || m_hi) |=> adc_trigger) else $error("adc trigger missing after match");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_r[1] && !(w_fl && pwdata[cdt_pkg::BIT_IRQ_HIGH])) |=> flag_r[1]) else $error("flag cleared by hw");
	chk_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> $past(enable_r) != 2'b00) else $error("irq without enable");
	chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep && !w_lc && !w_hc) |=> $stable(low_count_r) && $stable(high_count_r)) else $error("count in sleep");
	chk_ctrl_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(w_lx && !lo_tick && !hi_tick) |=> $stable(low_count_r)) else $error("ctrl write changed count");
	chk_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(m32 && !w_lc && !w_hc) |=> cnt32 == 32'h0000_0000) else $error("no wrap to zero");
	chk_hold_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && hit_lc) |=> hold_r == $past(high_count_r)) else $error("hold not latched");
	chk_gate_low: assert property (@(posedge pclk) disable iff (!presetn)
		(wide && lo_gate && !gate_lvl && !w_lc && !w_hc) |=> $stable(low_count_r)) else $error("gated count moved");
	chk_fall_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(wide && gate_end) |=> flag_r[1]) else $error("gate fall no flag");
	cov_wide_match: cover property (@(posedge pclk) disable iff (!presetn) m32);
	cov_gate_end:   cover property (@(posedge pclk) disable iff (!presetn) gate_end);
	cov_irq:        cover property (@(posedge pclk) disable iff (!presetn) irq);
	cov_split:      cover property (@(posedge pclk) disable iff (!presetn) m_lo && m_hi);
	cov_gate_run:   cover property (@(posedge pclk) disable iff (!presetn) wide && lo_gate && lo_tick);

	// reference tally of raw low ticks since the prescaler last restarted; a control write while
	// the timer is off changes the ratio without a restart, so the tally is untrusted until the next tick
	wire [7:0]   ps_tc_exp = (lo_ps == 2'b00) ? cdt_pkg::PS_TC1 :
		(lo_ps == 2'b01) ? cdt_pkg::PS_TC8 :
		(lo_ps == 2'b10) ? cdt_pkg::PS_TC64 : cdt_pkg::PS_TC256;
	logic [7:0]  ps_seen_r;
	logic        ps_clean_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_seen_r  <= 8'h00;
			ps_clean_r <= 1'b1;
		end else if (lo_ps_clr || lo_tick) begin
			ps_seen_r  <= 8'h00;
			ps_clean_r <= 1'b1;
		end else begin
			if (lo_tick_raw)
				ps_seen_r <= ps_seen_r + 8'h01;
			if (w_lx)
				ps_clean_r <= 1'b0;
		end
	end

	chk_ps_ratio: assert property (@(posedge pclk) disable iff (!presetn)
		(lo_tick && ps_clean_r) |-> ps_seen_r == ps_tc_exp)
		else $error("prescaler ratio wrong");
	chk_fall_once: assert property (@(posedge pclk) disable iff (!presetn)
		gate_fall |=> !gate_fall)
		else $error("gate fall pulse longer than one cycle");
	chk_hold_load: assert property (@(posedge pclk) disable iff (!presetn)
		(w_lc && wide) |=> high_count_r == $past(hold_r))
		else $error("hold not moved into high count");
	chk_low_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(m_lo && !w_lc) |=> low_count_r == cdt_pkg::ZERO16)
		else $error("low half did not wrap");
	chk_high_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(m_hi && !w_hc) |=> high_count_r == cdt_pkg::ZERO16)
		else $error("high half did not wrap");
	chk_low_flag: assert property (@(posedge pclk) disable iff (!presetn)
		m_lo |=> flag_r[0])
		else $error("low match set no flag");
	chk_adc_source: assert property (@(posedge pclk) disable iff (!presetn)
		adc_trigger |-> $past(m32 || m_hi))
		else $error("adc trigger without match");
	chk_wide_high: assert property (@(posedge pclk) disable iff (!presetn)
		(wide && !lo_tick && !w_lc && !w_hc) |=> $stable(high_count_r))
		else $error("high half moved on its own in wide mode");
	chk_gated_step: assert property (@(posedge pclk) disable iff (!presetn)
		(wide && lo_gate && gate_lvl && lo_run && lo_ps == 2'b00 && !m32 && !w_lc && !w_hc)
		|=> cnt32 == $past(cnt32) + 32'h0000_0001) else $error("gated count did not advance");
	chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
		(enable_r == 2'b00) |=> !irq)
		else $error("irq raised with enables clear");
	chk_low_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_r[0] && !(w_fl && pwdata[cdt_pkg::BIT_IRQ_LOW])) |=> flag_r[0])
		else $error("low flag cleared by hw");
	chk_hctrl_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(w_hx && !lo_tick && !hi_tick) |=> $stable(high_count_r))
		else $error("high ctrl write changed count");
endmodule : cdt_timer

// ==== verif/cascadable_dual_timer_32bit_bench.sv ====
// self-checking bench for the cascadable dual timer
`timescale 1ns/1ps
module cascadable_dual_timer_32bit_bench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        gate_input_pin;
	logic        high_clk_pin;
	logic        adc_trigger;
	logic        irq;
	logic [15:0] rd_v;
	logic        err_v;
	logic [15:0] a_v;
	int          adc_cnt;
	int          num_errors;
	int          comparisons;

	cdt_timer DUT (
		.pclk           (pclk),
		.presetn        (presetn),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.gate_input_pin (gate_input_pin),
		.high_clk_pin   (high_clk_pin),
		.adc_trigger    (adc_trigger),
		.irq            (irq)
	);

	always #5 pclk = ~pclk;

	// counted on the falling edge so the registered pulse is settled
	always @(negedge pclk) begin
		if (adc_trigger === 1'b1) adc_cnt++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// one apb transfer; pready, read data and error are taken at the rising edge that ends the access
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) chk(32'h0000_0001, 32'h0000_0000);
		rd_v  = prdata[15:0];
		err_v = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic t_reset_vals;
		logic [9:0]  idx [7] = '{cdt_pkg::IDX_LOW_COUNT, cdt_pkg::IDX_HIGH_HOLD, cdt_pkg::IDX_HIGH_COUNT,
			cdt_pkg::IDX_LOW_PERIOD, cdt_pkg::IDX_HIGH_PERIOD, cdt_pkg::IDX_LOW_CTRL, cdt_pkg::IDX_HIGH_CTRL};
		logic [15:0] exp [7] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, idx[i], 16'h0000);
			chk({16'h0000, rd_v}, {16'h0000, exp[i]});
		end
		apb(1'b0, 10'h0ff, 16'h0000);
		chk({15'h0000, err_v, rd_v}, 32'h0001_0000);
	endtask : t_reset_vals

	task automatic t_hold;
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0008);
		apb(1'b1, cdt_pkg::IDX_HIGH_HOLD, 16'h1234);
		apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h5678);
		apb(1'b0, cdt_pkg::IDX_HIGH_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, 32'h0000_1234);
		apb(1'b1, cdt_pkg::IDX_HIGH_HOLD, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_HIGH_CTRL, 16'h0002);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0008);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, 32'h0000_5678);
		apb(1'b0, cdt_pkg::IDX_HIGH_HOLD, 16'h0000);
		chk({16'h0000, rd_v}, 32'h0000_1234);
		apb(1'b1, cdt_pkg::IDX_HIGH_CTRL, 16'h0000);
	endtask : t_hold

	task automatic t_wide;
		apb(1'b1, cdt_pkg::IDX_IRQ_FLAG, 16'h00c0);
		apb(1'b1, cdt_pkg::IDX_LOW_PERIOD, 16'h0009);
		apb(1'b1, cdt_pkg::IDX_HIGH_PERIOD, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_HIGH_HOLD, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		adc_cnt = 0;
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h8008);
		cyc(100);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b0, cdt_pkg::IDX_IRQ_FLAG, 16'h0000);
		chk({24'h0, rd_v[7:0]}, 32'h0000_0080);
		apb(1'b1, cdt_pkg::IDX_IRQ_ENABLE, 16'h0080);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0008);
		chk({31'h0, adc_cnt >= 9 && adc_cnt <= 13}, 32'h0000_0001);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({31'h0, rd_v <= 16'h0009}, 32'h0000_0001);
		apb(1'b0, cdt_pkg::IDX_HIGH_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, 32'h0000_0000);
		cyc(50);
		apb(1'b0, cdt_pkg::IDX_IRQ_FLAG, 16'h0000);
		chk({31'h0, rd_v[7]}, 32'h0000_0001);
		apb(1'b1, cdt_pkg::IDX_IRQ_FLAG, 16'h0080);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, cdt_pkg::IDX_IRQ_ENABLE, 16'h0000);
	endtask : t_wide

	task automatic t_prescale;
		int sh [4] = '{0, 3, 6, 8};
		int d;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0000);
			apb(1'b1, cdt_pkg::IDX_LOW_PERIOD, 16'hffff);
			apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
			apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h8000 | 16'(s << 4));
			cyc(512);
			apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'(s << 4));
			apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
			d = int'(rd_v) - (512 >> sh[s]);
			chk({31'h0, d >= -1 && d <= 3}, 32'h0000_0001);
		end
	endtask : t_prescale

	task automatic t_sleep;
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h8000);
		apb(1'b1, cdt_pkg::IDX_SYS_CTRL, 16'h0001);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		a_v = rd_v;
		cyc(50);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, {16'h0000, a_v});
		apb(1'b1, cdt_pkg::IDX_SYS_CTRL, 16'h0000);
		cyc(20);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({31'h0, rd_v > a_v + 16'h000f}, 32'h0000_0001);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0000);
	endtask : t_sleep

	task automatic t_gate;
		apb(1'b1, cdt_pkg::IDX_IRQ_FLAG, 16'h00c0);
		apb(1'b1, cdt_pkg::IDX_HIGH_PERIOD, 16'hffff);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0008);
		apb(1'b1, cdt_pkg::IDX_HIGH_HOLD, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h8048);
		cyc(20);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, 32'h0000_0000);
		gate_input_pin <= 1'b1;
		cyc(40);
		gate_input_pin <= 1'b0;
		cyc(10);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		a_v = rd_v;
		chk({31'h0, a_v >= 16'd38 && a_v <= 16'd43}, 32'h0000_0001);
		apb(1'b0, cdt_pkg::IDX_IRQ_FLAG, 16'h0000);
		chk({31'h0, rd_v[7]}, 32'h0000_0001);
		cyc(20);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({16'h0000, rd_v}, {16'h0000, a_v});
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0000);
	endtask : t_gate

	task automatic t_split;
		apb(1'b1, cdt_pkg::IDX_IRQ_FLAG, 16'h00c0);
		apb(1'b1, cdt_pkg::IDX_LOW_PERIOD, 16'h0004);
		apb(1'b1, cdt_pkg::IDX_HIGH_PERIOD, 16'h0009);
		apb(1'b1, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		apb(1'b1, cdt_pkg::IDX_HIGH_COUNT, 16'h0000);
		adc_cnt = 0;
		apb(1'b1, cdt_pkg::IDX_HIGH_CTRL, 16'h8000);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h8000);
		cyc(60);
		apb(1'b1, cdt_pkg::IDX_HIGH_CTRL, 16'h0000);
		chk({31'h0, adc_cnt >= 5 && adc_cnt <= 8}, 32'h0000_0001);
		apb(1'b1, cdt_pkg::IDX_LOW_CTRL, 16'h0000);
		apb(1'b0, cdt_pkg::IDX_IRQ_FLAG, 16'h0000);
		chk({24'h0, rd_v[7:0]}, 32'h0000_00c0);
		apb(1'b0, cdt_pkg::IDX_LOW_COUNT, 16'h0000);
		chk({31'h0, rd_v <= 16'h0004}, 32'h0000_0001);
	endtask : t_split

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// the whole sequence needs about 2700 cycles
	initial begin
		repeat (50000) @(posedge pclk);
		num_errors++;
		summarize();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		gate_input_pin = 1'b0;
		high_clk_pin = 1'b0;
		adc_cnt = 0;
		num_errors = 0;
		comparisons = 0;
		cyc(5);
		presetn <= 1'b1;
		t_reset_vals();
		t_hold();
		t_wide();
		t_prescale();
		t_sleep();
		t_gate();
		t_split();
		summarize();
	end
endmodule : cascadable_dual_timer_32bit_bench
